/* File: center_aligned_pwm_timer.sv */
// 16-bit PWM timer with center- and edge-aligned channel outputs
`timescale 1ns/1ps
`include "pwm_timer_map.svh"
module center_aligned_pwm_timer
    import pwm_timer_pkg::*;
#(
    parameter int N_CH = 2
) (
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    input  wire logic [`PWM_CLKSEL_W-1:0]      counter_clock_select,
    input  wire logic [`PWM_PS_W-1:0]          prescale_select,
    input  wire logic                          center_mode,
    input  wire logic [`PWM_COUNT_W-1:0]       modulo_value,
    input  wire logic [N_CH-1:0][`PWM_COUNT_W-1:0] channel_value,
    output logic      [`PWM_COUNT_W-1:0]       counter_value,
    output logic                               counting_down,
    output logic      [N_CH-1:0]               pwm_out
);
    // Whole state of the core
    typedef struct packed {
        count_t                count;
        dir_t                  dir;
        logic [N_CH-1:0]       out;
        count_t [N_CH-1:0]     cv;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;
    logic        boundary;
    logic        tick;

    pwm_tick_if tk ();

    // Prescaler controls and returned tick
    assign tk.run             = (counter_clock_select != `PWM_CLKSEL_OFF);
    assign tk.prescale_select = prescale_select;
    assign tick               = tk.tick;

    pwm_prescaler u_prescaler (
        .core_clk (core_clk),
        .reset    (reset),
        .tk       (tk)
    );

    // Period reference point: top of the up-count, or wrap in edge mode
    assign boundary = (st_reg.count == modulo_value) &&
                      (!center_mode || st_reg.dir == DIR_UP);

    // Counter, period latch and channel compare
    always_comb begin
        count_t      cv_use;
        logic        neg;
        logic        full;
        cv_use  = `PWM_CV_ZERO;
        neg     = 1'b0;
        full    = 1'b0;
        st_next = st_reg;
        if (tick) begin
            for (int i = 0; i < N_CH; i++) begin
                // New duty is taken at the period boundary only
                cv_use = boundary ? channel_value[i] : st_reg.cv[i];
                st_next.cv[i] = cv_use;
                neg  = cv_use[`PWM_SIGN_BIT];
                full = center_mode && (cv_use == modulo_value);
                if (neg) begin
                    if (boundary) begin
                        st_next.out[i] = 1'b0;
                    end
                end else if (center_mode) begin
                    if (boundary) begin
                        st_next.out[i] = full;
                    end else if (!full && st_reg.count == cv_use) begin
                        // Down-count match sets unless the value is zero, up-count match clears
                        st_next.out[i] = (st_reg.dir == DIR_DOWN) &&
                                         (cv_use != `PWM_CV_ZERO);
                    end
                end else begin
                    if (boundary) begin
                        st_next.out[i] = (cv_use != `PWM_CV_ZERO);
                    end else if (st_reg.count == cv_use) begin
                        st_next.out[i] = 1'b0;
                    end
                end
            end
            // Counter movement
            if (!center_mode) begin
                st_next.dir   = DIR_UP;
                st_next.count = boundary ? `PWM_COUNT_RESET
                                         : st_reg.count + count_t'(1);
            end else if (modulo_value == `PWM_COUNT_RESET) begin
                st_next.count = `PWM_COUNT_RESET;
            end else begin
                case (st_reg.dir)
                    DIR_UP: begin
                        if (st_reg.count >= modulo_value) begin
                            st_next.dir   = DIR_DOWN;
                            st_next.count = modulo_value - count_t'(1);
                        end else begin
                            st_next.count = st_reg.count + count_t'(1);
                        end
                    end
                    DIR_DOWN: begin
                        if (st_reg.count == `PWM_COUNT_RESET) begin
                            st_next.dir   = DIR_UP;
                            st_next.count = count_t'(1);
                        end else begin
                            st_next.count = st_reg.count - count_t'(1);
                        end
                    end
                    default: begin
                        st_next.dir   = DIR_UP;
                        st_next.count = `PWM_COUNT_RESET;
                    end
                endcase
            end
        end
    end

    // State register; counter starts at zero, outputs low
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_reg.count <= `PWM_COUNT_RESET;
            st_reg.dir   <= DIR_DOWN;
            st_reg.out   <= '0;
            st_reg.cv    <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    always_comb begin
        counter_value = st_reg.count;
        counting_down = st_reg.dir[1]; // One-hot down bit
        pwm_out       = st_reg.out;
    end

    // Helper: no tick seen since reset
    logic seen_tick_reg;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seen_tick_reg <= 1'b0;
        end else if (tick) begin
            seen_tick_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_count_upward: assert property (
        tick && center_mode && st_reg.dir == DIR_UP && st_reg.count < modulo_value
        |=> st_reg.count == $past(st_reg.count) + 16'h0001)
        else $error("center count did not step up");
    chk_top_reverse: assert property (
        tick && center_mode && boundary && modulo_value != 16'h0000
        |=> st_reg.dir == DIR_DOWN && st_reg.count == $past(modulo_value) - 16'h0001)
        else $error("counter did not reverse at modulo");
    chk_period_latch: assert property (
        tick && boundary |=> st_reg.cv == $past(channel_value))
        else $error("channel value not taken at period start");
    chk_zero_once: assert property (
        tick && center_mode && st_reg.dir == DIR_DOWN && st_reg.count == 16'h0000
        && modulo_value != 16'h0000 |=> st_reg.dir == DIR_UP && st_reg.count == 16'h0001)
        else $error("zero count not single or not reversed");
    chk_hold_no_tick: assert property (
        !tick |=> $stable(st_reg.out) && $stable(st_reg.count))
        else $error("state moved without a tick");
    chk_reset_count: assert property (
        !seen_tick_reg |-> st_reg.count == 16'h0000 && st_reg.out == '0)
        else $error("counter or outputs not cleared by reset");
    chk_edge_wrap: assert property (
        tick && !center_mode && boundary |=> st_reg.count == 16'h0000)
        else $error("edge count did not wrap at modulo");

    // Per-channel duty checks
    for (genvar g = 0; g < N_CH; g++) begin : g_chk
        chk_negative_idle: assert property (
            tick && boundary && channel_value[g][15] |=> !pwm_out[g] ##1 !pwm_out[g])
            else $error("negative channel value drove output active");
        chk_full_duty: assert property (
            tick && center_mode && boundary && channel_value[g] == modulo_value
            |=> pwm_out[g])
            else $error("full duty channel not active");
        chk_down_match_set: assert property (
            tick && center_mode && !boundary && st_reg.dir == DIR_DOWN
            && st_reg.count == st_reg.cv[g] && !st_reg.cv[g][15]
            && st_reg.cv[g] != 16'h0000 && st_reg.cv[g] != modulo_value |=> pwm_out[g])
            else $error("down-count compare did not set output");
        chk_negative_range: assert property (
            tick && boundary && channel_value[g] >= 16'h8000 |=> st_reg.out[g] == 1'b0)
            else $error("channel value in negative range gave duty");
        chk_up_match_clear: assert property (
            tick && center_mode && !boundary && st_reg.dir == DIR_UP
            && st_reg.count == st_reg.cv[g] && !st_reg.cv[g][`PWM_SIGN_BIT] |=> !pwm_out[g])
            else $error("up-count compare did not clear output");
        chk_edge_match_clear: assert property (
            tick && !center_mode && !boundary && st_reg.count == st_reg.cv[g]
            && !st_reg.cv[g][`PWM_SIGN_BIT] |=> !pwm_out[g])
            else $error("edge compare did not clear output");
        chk_edge_period_set: assert property (
            tick && !center_mode && boundary && channel_value[g] != 16'h0000
            && !channel_value[g][`PWM_SIGN_BIT] |=> pwm_out[g])
            else $error("edge period start did not set output");
    end

    cov_center_period: cover property (tick && center_mode && boundary);
    cov_edge_period: cover property (tick && !center_mode && boundary);
    cov_zero_turn: cover property (tick && center_mode && st_reg.count == 16'h0000
        && st_reg.dir == DIR_DOWN);
    cov_full_duty: cover property (tick && center_mode && boundary
        && channel_value[0] == modulo_value);
    cov_negative_duty: cover property (tick && boundary && channel_value[0][`PWM_SIGN_BIT]);
endmodule // center_aligned_pwm_timer

/* File: pwm_load_model.sv */
// External load that integrates PWM active time per channel
`timescale 1ns/1ps
module pwm_load_model #(
    parameter int N_CH = 2
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic [N_CH-1:0]       pwm_in,
    output logic      [N_CH-1:0][31:0] high_cnt
);
    // Count cycles seen at the active level
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            high_cnt <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                high_cnt[c] <= high_cnt[c] + 32'(pwm_in[c]);
            end
        end
    end
endmodule // pwm_load_model

/* File: pwm_prescaler.sv */
// Free-running clock prescaler that produces counter ticks
`timescale 1ns/1ps
`include "pwm_timer_map.svh"
module pwm_prescaler
    import pwm_timer_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    pwm_tick_if.src  tk
);
    prescaler_state_t st_reg;
    prescaler_state_t st_next;
    divider_t         mask;

    // Divider keeps its value across prescale changes
    always_comb begin
        st_next = st_reg;
        mask = divider_t'((8'h01 << tk.prescale_select) - 8'h01);
        st_next.tick = 1'b0;
        if (tk.run) begin
            st_next.div = st_reg.div + divider_t'(1);
            st_next.tick = ((st_reg.div & mask) == mask);
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_reg <= '{div: `PWM_DIV_RESET, tick: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Tick comes straight from its flop
    assign tk.tick = st_reg.tick;

    chk_divider_not_cleared: assert property (@(posedge core_clk) disable iff (reset)
        tk.run && $changed(tk.prescale_select) |=> st_reg.div == $past(st_reg.div) + 7'h01)
        else $error("prescaler divider disturbed by prescale change");
endmodule // pwm_prescaler

/* File: pwm_tick_if.sv */
// Carrier between the prescaler and the counter core
`timescale 1ns/1ps
interface pwm_tick_if;
    import pwm_timer_pkg::*;
    logic      run;
    prescale_t prescale_select;
    logic      tick;

    modport src (input run, input prescale_select, output tick);
    modport dst (output run, output prescale_select, input tick);
endinterface

/* File: pwm_timer_map.svh */
// Constants for the center-aligned PWM timer
`ifndef PWM_TIMER_MAP_SVH
`define PWM_TIMER_MAP_SVH

`define PWM_COUNT_W      16
`define PWM_COUNT_RESET  16'h0000
`define PWM_CV_ZERO      16'h0000
`define PWM_SIGN_BIT     15
`define PWM_PS_W         3
`define PWM_DIV_W        7
`define PWM_DIV_RESET    7'h00
`define PWM_CLKSEL_W     2
`define PWM_CLKSEL_OFF   2'h0

`endif

/* File: pwm_timer_pkg.sv */
// Types shared by the PWM timer modules
`include "pwm_timer_map.svh"
package pwm_timer_pkg;
    typedef logic [`PWM_COUNT_W-1:0] count_t;
    typedef logic [`PWM_PS_W-1:0]    prescale_t;
    typedef logic [`PWM_DIV_W-1:0]   divider_t;

    // Counting direction, one-hot
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;

    // Prescaler state
    typedef struct packed {
        divider_t div;
        logic     tick;
    } prescaler_state_t;
endpackage

/* File: tb_top.sv */
// Self-checking bench for the PWM timer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import pwm_timer_pkg::*;
    localparam int N_CH = 2;
    logic                  core_clk, reset, center_mode, counting_down;
    logic [1:0]            counter_clock_select;
    prescale_t             prescale_select;
    count_t                modulo_value, counter_value, prev;
    count_t [N_CH-1:0]     channel_value;
    logic [N_CH-1:0]       pwm_out;
    logic [N_CH-1:0][31:0] high_cnt;
    int error_cnt, comparisons, m_cnt, m_dn, m_mod, m_cm, gap;
    int m_lat[N_CH], m_o[N_CH], m_cv[N_CH], hi_exp[N_CH];
    int tcm[5] = '{1, 1, 1, 0, 0};
    int tmd[5] = '{4, 6, 5, 5, 8};
    int tc0[5] = '{2, 16'hffff, 5, 2, 0};
    int tc1[5] = '{4, 16'h8000, 0, 7, 8};

    center_aligned_pwm_timer #(.N_CH(N_CH)) u_dut (.core_clk(core_clk), .reset(reset),
        .counter_clock_select(counter_clock_select), .prescale_select(prescale_select),
        .center_mode(center_mode), .modulo_value(modulo_value), .channel_value(channel_value),
        .counter_value(counter_value), .counting_down(counting_down), .pwm_out(pwm_out));
    pwm_load_model #(.N_CH(N_CH)) u_load (.core_clk(core_clk), .reset(reset),
        .pwm_in(pwm_out), .high_cnt(high_cnt));

    task conclude;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Reference: outputs on compare, then count moves
    task step_model;
        for (int c = 0; c < N_CH; c++) begin
            if (m_cnt == m_mod && (!m_cm || !m_dn)) begin
                m_lat[c] = m_cv[c];
                m_o[c] = m_cm ? (m_cv[c] == m_mod) : (m_cv[c] != 0 && m_cv[c] < 32768);
            end else if (m_cnt == m_lat[c] && (!m_cm || m_lat[c] != 0)) begin
                m_o[c] = m_cm ? m_dn : 0;
            end
        end
        if (!m_cm) m_cnt = (m_cnt == m_mod) ? 0 : m_cnt + 1;
        else if (m_dn) begin m_dn = (m_cnt != 0); m_cnt = m_dn ? m_cnt - 1 : 1; end
        else begin m_dn = (m_cnt == m_mod); m_cnt = m_dn ? m_cnt - 1 : m_cnt + 1; end
    endtask

    // Reset, configure, align reference to first count
    task start(input int cm, input int md);
        @(posedge core_clk);
        center_mode <= 1'(cm);
        modulo_value <= 16'(md);
        prescale_select <= '0;
        counter_clock_select <= 2'h1;
        for (int c = 0; c < N_CH; c++) channel_value[c] <= 16'(m_cv[c]);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        #1;
        `CHK(counter_value, 16'h0000)
        `CHK(pwm_out, 2'h0)
        m_cm = cm; m_mod = md; m_cnt = 0; m_dn = 1;
        for (int c = 0; c < N_CH; c++) begin m_lat[c] = 0; m_o[c] = 0; hi_exp[c] = 0; end
        for (int i = 0; i < 10 && counter_value !== 16'h0001; i++) @(posedge core_clk) #1;
        if (counter_value !== 16'h0001) begin error_cnt++; conclude(); end
        step_model();
    endtask

    // Run n ticks, optionally changing channel values mid-period
    task run(input int n, input int chg);
        int c;
        repeat (n) begin
            @(posedge core_clk);
            step_model();
            if (chg && $urandom % 16 == 0) begin
                c = $urandom % N_CH;
                case ($urandom % 4)
                    0: m_cv[c] = 32768 + $urandom % 32768;
                    1: m_cv[c] = m_mod;
                    2: m_cv[c] = 1 + $urandom % m_mod;
                    default: m_cv[c] = 0;
                endcase
                channel_value[c] <= 16'(m_cv[c]);
            end
            #1;
            `CHK(counter_value, 16'(m_cnt))
            if (m_cm) `CHK(counting_down, 1'(m_dn))
            for (int k = 0; k < N_CH; k++) begin
                `CHK(pwm_out[k], 1'(m_o[k]))
                `CHK(high_cnt[k], 32'(hi_exp[k]))
                hi_exp[k] += m_o[k];
            end
        end
    endtask

    // Cycles until the count next moves, bounded
    task next_gap;
        prev = counter_value;
        gap = 0;
        while (counter_value === prev && gap < 300) begin @(posedge core_clk) #1; gap++; end
        if (gap >= 300) begin error_cnt++; conclude(); end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Main sequence
    initial begin
        reset = 1'b1; center_mode = 1'b1; counter_clock_select = 2'h1;
        prescale_select = '0; modulo_value = 16'h0004; channel_value = '0;
        error_cnt = 0; comparisons = 0;
        void'($urandom(32'h67c3d176));
        repeat (4) @(posedge core_clk);
        for (int t = 0; t < 5; t++) begin
            m_cv[0] = tc0[t]; m_cv[1] = tc1[t];
            start(tcm[t], tmd[t]);
            run(70, 0);
        end
        repeat (8) begin
            m_cv[0] = $urandom % 20; m_cv[1] = 32768 + $urandom % 32768;
            start($urandom % 2, 3 + $urandom % 14);
            run(300, 1);
        end
        m_cv[0] = 5; m_cv[1] = 9;
        start(1, 1000);
        @(posedge core_clk) modulo_value <= 16'h0000;
        repeat (4) @(posedge core_clk);
        #1 `CHK(counter_value, 16'h0000)
        @(posedge core_clk) modulo_value <= 16'h03e8;
        for (int ps = 1; ps < 8; ps++) begin
            @(posedge core_clk) prescale_select <= 3'(ps);
            next_gap();
            next_gap();
            `CHK(gap >= 1 && gap <= (1 << ps), 1'b1)
            next_gap();
            `CHK(32'(gap), 32'(1 << ps))
        end
        @(posedge core_clk) counter_clock_select <= 2'h0;
        repeat (4) @(posedge core_clk);
        #1 prev = counter_value;
        repeat (20) @(posedge core_clk);
        #1 `CHK(counter_value, prev)
        @(posedge core_clk) counter_clock_select <= 2'(1 + $urandom % 3);
        next_gap();
        conclude();
    end
endmodule // tb_top
